/* File: verilog/flec_link.sv */
// link and transport frame error control: receive and transmit handshakes
`timescale 1ns/1ps
module flec_link (
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	input  wire flec_pkg::flec_rx_t     rx,
	input  wire logic                   rx_crc_bad,
	input  wire flec_pkg::flec_tp_err_t tp_err,
	output flec_pkg::flec_word_t        rx_word,
	output logic                        rx_word_valid,
	output logic                        rx_frame_done,
	output logic                        rx_frame_err,
	output flec_pkg::flec_lnk_err_t     lnk_err,
	input  wire logic                   tx_req,
	input  wire logic                   tx_retryable,
	input  wire flec_pkg::flec_word_t   tx_in,
	input  wire logic                   tx_in_valid,
	output logic                        tx_in_ready,
	input  wire logic [31:0]            tx_crc,
	output flec_pkg::flec_prim_t        tx_prim,
	output logic [31:0]                 tx_data,
	output logic                        tx_done,
	output logic                        tx_nak,
	output logic                        tx_retry_ok,
	output logic                        tx_ack_timeout,
	input  wire logic                   cmd_start,
	output logic                        end_status_err,
	input  wire logic [15:0]            ierr_clr,
	output logic [15:0]                 interface_error_register
);
	// ************************************************************
	// declarations
	// ************************************************************
	flec_pkg::flec_rx_st_t rx_st;
	flec_pkg::flec_rx_st_t next_rx_st;
	flec_pkg::flec_tx_st_t tx_st;
	flec_pkg::flec_tx_st_t next_tx_st;
	flec_pkg::flec_prim_t  next_tx_prim;
	flec_pkg::flec_word_t  buf_word;
	logic [31:0]           next_tx_data;
	logic                  buf_valid;
	logic                  buf_pop;
	logic                  err_acc;
	logic                  tx_corrupt;
	logic                  tx_retry_lat;
	logic [flec_pkg::TMO_W-1:0] tmo_cnt;
	logic [15:0]           ierr_set;
	logic                  pv;
	logic                  bad_in_frame;
	logic                  tx_quiet;
	logic                  tp_any;
	logic                  ev_sof;
	logic                  ev_eof;
	logic                  ev_code;
	logic                  ev_proto;
	logic                  ev_xabort;
	logic                  ev_crc;
	logic                  ev_tp;
	logic                  ev_udr;
	logic                  ev_tmo;
	logic                  ev_ack_end;
	logic                  final_err;

	// ************************************************************
	// receive event decode
	// ************************************************************
	assign pv           = rx.valid && (rx.prim != flec_pkg::P_DATA);
	assign bad_in_frame = rx.valid && (rx.prim inside {flec_pkg::P_X_RDY, flec_pkg::P_R_RDY,
		flec_pkg::P_SOF, flec_pkg::P_WTRM, flec_pkg::P_R_OK, flec_pkg::P_R_ERR});
	assign tx_quiet     = (tx_st == flec_pkg::TX_IDLE) || (tx_st == flec_pkg::TX_XRDY);
	assign tp_any       = |tp_err;
	assign ev_sof       = (rx_st == flec_pkg::RX_XRDY) && pv && (rx.prim == flec_pkg::P_SOF);
	assign ev_eof       = (rx_st == flec_pkg::RX_RECV) && pv && (rx.prim == flec_pkg::P_EOF);
	assign ev_code      = (rx_st == flec_pkg::RX_RECV) && rx.valid && rx.code_err;
	assign ev_proto     = (rx_st == flec_pkg::RX_RECV) && bad_in_frame;
	assign ev_crc       = ev_eof && rx_crc_bad;
	assign ev_tp        = (rx_st == flec_pkg::RX_RECV) && tp_any;
	assign ev_xabort    = (rx_st == flec_pkg::RX_XRDY) && pv && !(rx.prim inside
		{flec_pkg::P_X_RDY, flec_pkg::P_SOF, flec_pkg::P_ALIGN, flec_pkg::P_CONT});
	assign final_err    = err_acc || ev_code || ev_crc || ev_tp;
	assign ev_ack_end   = (rx_st == flec_pkg::RX_ACK) && pv && (rx.prim == flec_pkg::P_SYNC);

	// ************************************************************
	// receive state machine
	// ************************************************************
	always_comb begin
		next_rx_st = rx_st;
		case (rx_st)
			flec_pkg::RX_IDLE: begin
				if (pv && tx_quiet && rx.prim == flec_pkg::P_X_RDY) begin
					next_rx_st = flec_pkg::RX_XRDY;
				// [R6] early start parks
				end else if (pv && tx_quiet && rx.prim == flec_pkg::P_SOF) begin
					next_rx_st = flec_pkg::RX_HOLD;
				end
			end
			flec_pkg::RX_XRDY: begin
				if (ev_sof) begin
					next_rx_st = flec_pkg::RX_RECV;
				// [R4] [R3] abort to idle
				end else if (ev_xabort) begin
					next_rx_st = flec_pkg::RX_IDLE;
				end
			end
			flec_pkg::RX_RECV: begin
				// [R2] bad primitive in frame
				if (ev_eof || ev_proto) begin
					next_rx_st = flec_pkg::RX_ACK;
				end else if (pv && rx.prim == flec_pkg::P_SYNC) begin
					next_rx_st = flec_pkg::RX_IDLE;
				end
			end
			flec_pkg::RX_ACK: begin
				if (ev_ack_end) begin
					next_rx_st = flec_pkg::RX_IDLE;
				end
			end
			flec_pkg::RX_HOLD: begin
				if (pv && rx.prim == flec_pkg::P_SYNC) begin
					next_rx_st = flec_pkg::RX_IDLE;
				end
			end
			default: next_rx_st = flec_pkg::RX_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_st <= flec_pkg::RX_IDLE;
		end else begin
			rx_st <= next_rx_st;
		end
	end

	// [R1] [R21] accumulate per frame
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			err_acc <= 1'b0;
		end else if (ev_sof) begin
			err_acc <= 1'b0;
		end else if (ev_code || ev_proto || ev_crc || ev_tp) begin
			err_acc <= 1'b1;
		end
	end

	// ************************************************************
	// receive outputs to transport
	// ************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_word       <= '0;
			rx_word_valid <= 1'b0;
			rx_frame_done <= 1'b0;
			rx_frame_err  <= 1'b0;
			lnk_err       <= '0;
		end else begin
			rx_word_valid <= (rx_st == flec_pkg::RX_RECV) && rx.valid && (rx.prim == flec_pkg::P_DATA);
			rx_word.data  <= rx.data;
			rx_word.last  <= 1'b0;
			rx_frame_done <= ev_eof;
			// [R12] [R15] [R17] [R18] [R19] transport errors fail frame
			rx_frame_err  <= ev_eof ? final_err : rx_frame_err;
			// [R11] [R9] [R10] private error port
			lnk_err.crc        <= ev_crc;
			lnk_err.code       <= ev_code;
			lnk_err.proto      <= ev_proto;
			lnk_err.xrdy_abort <= ev_xabort;
		end
	end

	// ************************************************************
	// transmit path
	// ************************************************************
	flec_buf2 #(
		.W     ($bits(flec_pkg::flec_word_t)),
		.DEPTH (2)
	) u_buf (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_data   (tx_in),
		.in_valid  (tx_in_valid),
		.in_ready  (tx_in_ready),
		.out_data  (buf_word),
		.out_valid (buf_valid),
		.out_ready (buf_pop)
	);

	assign buf_pop = (tx_st == flec_pkg::TX_DATA) && (rx_st == flec_pkg::RX_IDLE);
	assign ev_udr  = buf_pop && !buf_valid;
	// flag once, so a cleared register bit stays cleared while the wait goes on
	assign ev_tmo  = (tx_st == flec_pkg::TX_WTRM) && !tx_ack_timeout
		&& (tmo_cnt == flec_pkg::TMO_W'(flec_pkg::ACK_TIMEOUT_CYC - 1));

	always_comb begin
		next_tx_st = tx_st;
		case (tx_st)
			flec_pkg::TX_IDLE: begin
				if (tx_req && rx_st == flec_pkg::RX_IDLE && !(pv && rx.prim == flec_pkg::P_X_RDY)) begin
					next_tx_st = flec_pkg::TX_XRDY;
				end
			end
			flec_pkg::TX_XRDY: begin
				// [R5] wait with no recovery
				if (rx_st != flec_pkg::RX_IDLE) begin
					next_tx_st = flec_pkg::TX_IDLE;
				end else if (pv && rx.prim == flec_pkg::P_R_RDY) begin
					next_tx_st = flec_pkg::TX_SOF;
				end
			end
			flec_pkg::TX_SOF: next_tx_st = flec_pkg::TX_DATA;
			flec_pkg::TX_DATA: begin
				if (ev_udr || (buf_pop && buf_word.last)) begin
					next_tx_st = flec_pkg::TX_CRC;
				end
			end
			flec_pkg::TX_CRC: next_tx_st = flec_pkg::TX_EOF;
			flec_pkg::TX_EOF: next_tx_st = flec_pkg::TX_WTRM;
			flec_pkg::TX_WTRM: begin
				// [R8] [R7] only valid terminators end the wait
				if (pv && rx.prim inside {flec_pkg::P_SYNC, flec_pkg::P_R_OK, flec_pkg::P_R_ERR}) begin
					next_tx_st = flec_pkg::TX_IDLE;
				end
			end
			default: next_tx_st = flec_pkg::TX_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_st <= flec_pkg::TX_IDLE;
		end else begin
			tx_st <= next_tx_st;
		end
	end

	// [R16] underrun forces a bad crc
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_corrupt   <= 1'b0;
			tx_retry_lat <= 1'b0;
		end else begin
			if (tx_st == flec_pkg::TX_SOF) begin
				tx_corrupt <= 1'b0;
			end else if (ev_udr) begin
				tx_corrupt <= 1'b1;
			end
			if (tx_st == flec_pkg::TX_IDLE && next_tx_st == flec_pkg::TX_XRDY) begin
				tx_retry_lat <= tx_retryable;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tmo_cnt        <= '0;
			tx_ack_timeout <= 1'b0;
		end else if (tx_st != flec_pkg::TX_WTRM) begin
			tmo_cnt        <= '0;
			tx_ack_timeout <= 1'b0;
		end else if (ev_tmo) begin
			tx_ack_timeout <= 1'b1;
		end else if (!tx_ack_timeout) begin
			tmo_cnt <= flec_pkg::TMO_W'(tmo_cnt + 1'b1);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_done     <= 1'b0;
			tx_nak      <= 1'b0;
			tx_retry_ok <= 1'b0;
		end else begin
			tx_done <= (tx_st == flec_pkg::TX_WTRM) && pv && (rx.prim == flec_pkg::P_R_OK);
			tx_nak  <= (tx_st == flec_pkg::TX_WTRM) && pv
				&& (rx.prim == flec_pkg::P_R_ERR || rx.prim == flec_pkg::P_SYNC);
			// [R14] resend only when state unchanged
			tx_retry_ok <= (tx_st == flec_pkg::TX_WTRM) && pv && tx_retry_lat
				&& (rx.prim == flec_pkg::P_R_ERR || rx.prim == flec_pkg::P_SYNC);
		end
	end

	// ************************************************************
	// line output
	// ************************************************************
	always_comb begin
		next_tx_prim = flec_pkg::P_SYNC;
		next_tx_data = '0;
		case (rx_st)
			flec_pkg::RX_XRDY: next_tx_prim = flec_pkg::P_R_RDY;
			flec_pkg::RX_RECV: next_tx_prim = flec_pkg::P_R_IP;
			// [R1] [R21] final handshake
			flec_pkg::RX_ACK:  next_tx_prim = err_acc ? flec_pkg::P_R_ERR : flec_pkg::P_R_OK;
			flec_pkg::RX_HOLD: next_tx_prim = flec_pkg::P_SYNC;
			default: begin
				case (tx_st)
					flec_pkg::TX_XRDY: next_tx_prim = flec_pkg::P_X_RDY;
					flec_pkg::TX_SOF:  next_tx_prim = flec_pkg::P_SOF;
					// [R16] filler keeps frame
					flec_pkg::TX_DATA: begin
						next_tx_prim = flec_pkg::P_DATA;
						next_tx_data = buf_valid ? buf_word.data : ~tx_crc;
					end
					flec_pkg::TX_CRC: begin
						next_tx_prim = flec_pkg::P_DATA;
						next_tx_data = tx_corrupt ? ~tx_crc : tx_crc;
					end
					flec_pkg::TX_EOF:  next_tx_prim = flec_pkg::P_EOF;
					flec_pkg::TX_WTRM: next_tx_prim = flec_pkg::P_WTRM;
					default:           next_tx_prim = flec_pkg::P_SYNC;
				endcase
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_prim <= flec_pkg::P_SYNC;
			tx_data <= '0;
		end else begin
			tx_prim <= next_tx_prim;
			tx_data <= next_tx_data;
		end
	end

	// ************************************************************
	// error register and ending status
	// ************************************************************
	always_comb begin
		ierr_set                      = '0;
		ierr_set[flec_pkg::B_CRC]      = ev_crc;
		ierr_set[flec_pkg::B_CODE]     = ev_code;
		ierr_set[flec_pkg::B_PROTO]    = ev_proto;
		ierr_set[flec_pkg::B_XABORT]   = ev_xabort;
		ierr_set[flec_pkg::B_TYPE]     = ev_tp && tp_err.type_bad;
		ierr_set[flec_pkg::B_LEN]      = ev_tp && tp_err.len_bad;
		ierr_set[flec_pkg::B_PIO]      = ev_tp && tp_err.pio_mismatch;
		ierr_set[flec_pkg::B_SEQ]      = ev_tp && tp_err.seq_err;
		ierr_set[flec_pkg::B_RX_OVF]   = ev_tp && tp_err.rx_ovf;
		ierr_set[flec_pkg::B_INTERNAL] = ev_tp && tp_err.internal;
		ierr_set[flec_pkg::B_TX_UDR]   = ev_udr;
		ierr_set[flec_pkg::B_NAK_RCVD] = (tx_st == flec_pkg::TX_WTRM) && pv
			&& (rx.prim == flec_pkg::P_R_ERR);
		ierr_set[flec_pkg::B_ACK_TMO]  = ev_tmo;
	end

	// [R11] [R20] sticky, set wins over clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			interface_error_register <= flec_pkg::IERR_RST;
		end else begin
			interface_error_register <= (interface_error_register & ~ierr_clr) | ierr_set;
		end
	end

	// [R13] any negative handshake of the command
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			end_status_err <= 1'b0;
		end else if ((ev_eof && final_err) || ev_proto || ierr_set[flec_pkg::B_NAK_RCVD]) begin
			end_status_err <= 1'b1;
		end else if (cmd_start) begin
			end_status_err <= 1'b0;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_ack_err;
		(rx_st == flec_pkg::RX_ACK) ##1 (tx_prim == flec_pkg::P_R_ERR);
	endsequence

	property p_crc_nak;
		@(posedge clk_sys) disable iff (rst) ev_crc |=> lnk_err.crc ##0 s_ack_err;
	endproperty
	a_crc_nak: assert property (p_crc_nak) else $error("crc error not answered"); // [R9]

	property p_code_latch;
		@(posedge clk_sys) disable iff (rst) ev_code |=> err_acc;
	endproperty
	a_code_latch: assert property (p_code_latch) else $error("code error not held"); // [R10]

	property p_ok_clean;
		@(posedge clk_sys) disable iff (rst)
			(rx_st == flec_pkg::RX_ACK && !err_acc) |=> (tx_prim == flec_pkg::P_R_OK);
	endproperty
	a_ok_clean: assert property (p_ok_clean) else $error("clean frame not acked"); // [R21]

	property p_proto_nak;
		@(posedge clk_sys) disable iff (rst) ev_proto |=> s_ack_err;
	endproperty
	a_proto_nak: assert property (p_proto_nak) else $error("bad transition not nakked"); // [R2]

	property p_xabort;
		@(posedge clk_sys) disable iff (rst)
			ev_xabort |=> (rx_st == flec_pkg::RX_IDLE) && lnk_err.xrdy_abort;
	endproperty
	a_xabort: assert property (p_xabort) else $error("x_rdy abort not reported"); // [R4]

	property p_hold_sync;
		@(posedge clk_sys) disable iff (rst)
			(rx_st == flec_pkg::RX_HOLD) |=> (tx_prim == flec_pkg::P_SYNC);
	endproperty
	a_hold_sync: assert property (p_hold_sync) else $error("early sof not held"); // [R6]

	property p_wtrm_wait;
		@(posedge clk_sys) disable iff (rst) (tx_st == flec_pkg::TX_WTRM && !(pv && rx.prim inside
			{flec_pkg::P_SYNC, flec_pkg::P_R_OK, flec_pkg::P_R_ERR})) |=> (tx_st == flec_pkg::TX_WTRM);
	endproperty
	a_wtrm_wait: assert property (p_wtrm_wait) else $error("left wait on stray primitive"); // [R8]

	property p_udr_crc;
		@(posedge clk_sys) disable iff (rst)
			(ev_udr && rx_st == flec_pkg::RX_IDLE) |=> ##1 (tx_data == ~tx_crc);
	endproperty
	a_udr_crc: assert property (p_udr_crc) else $error("underrun crc not corrupted"); // [R16]

	property p_ierr_set;
		@(posedge clk_sys) disable iff (rst)
			(ev_tp && tp_err.rx_ovf) |=> interface_error_register[flec_pkg::B_RX_OVF];
	endproperty
	a_ierr_set: assert property (p_ierr_set) else $error("overflow not recorded"); // [R20]

endmodule : flec_link

/* File: inc/flec_pkg.sv */
// shared types and constants of the frame link error control block
// Contract
// [R1] link errors seen during a received frame are held until its end-of-frame handshake
// [R2] invalid transition after start-of-frame answers the sender with R_ERR
// [R3] invalid transition outside a frame returns the link straight to idle
// [R4] X_RDY followed by anything but SOF notifies transport and returns idle
// [R5] X_RDY sent without R_RDY back: no link recovery, keep waiting
// [R6] SOF before our R_RDY: stay idle sending SYNC until sender goes idle
// [R7] no R_OK or R_ERR after EOF and WTRM within timeout: flag only
// [R8] after EOF ignore all but SYNC, R_OK, R_ERR and keep waiting
// [R9] CRC mismatch at EOF: flag transport, answer R_ERR, then idle
// [R10] disparity or code violation in a frame is latched, then R_ERR and notify
// [R11] link errors go to transport on a private port and to the error register
// [R12] transport errors turn the frame handshake into R_ERR
// [R13] any R_ERR handshake of a command shows in its ending status
// [R14] a failed frame may be resent only when system state is unchanged
// [R15] receive FIFO overflow answers R_ERR, handled like a bad CRC
// [R16] transmit underrun closes the frame with EOF and a forced bad CRC
// [R17] transport internal error fails the frame like a bad CRC
// [R18] bad CRC, unknown type or wrong length fails the received frame
// [R19] PIO count mismatch or event sequence error fails the frame
// [R20] transport errors are also recorded in the error register
// [R21] clean frame gets R_OK; error accumulator clears at each new frame
package flec_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_PS   = 4000;
	localparam int ACK_TIMEOUT_NS  = 10000;
	// least wait, rounded up
	localparam int ACK_TIMEOUT_CYC = (ACK_TIMEOUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TMO_W           = 12;

	// ************************************************************
	// error register layout
	// ************************************************************
	localparam int IERR_W        = 16;
	localparam logic [15:0] IERR_RST = 16'h0000;
	localparam int B_CRC         = 0;
	localparam int B_CODE        = 1;
	localparam int B_PROTO       = 2;
	localparam int B_XABORT      = 3;
	localparam int B_TYPE        = 4;
	localparam int B_LEN         = 5;
	localparam int B_PIO         = 6;
	localparam int B_SEQ         = 7;
	localparam int B_RX_OVF      = 8;
	localparam int B_INTERNAL    = 9;
	localparam int B_TX_UDR      = 10;
	localparam int B_NAK_RCVD    = 11;
	localparam int B_ACK_TMO     = 12;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [3:0] {
		P_SYNC  = 4'h0,
		P_X_RDY = 4'h1,
		P_R_RDY = 4'h2,
		P_SOF   = 4'h3,
		P_EOF   = 4'h4,
		P_WTRM  = 4'h5,
		P_R_OK  = 4'h6,
		P_R_ERR = 4'h7,
		P_R_IP  = 4'h8,
		P_HOLD  = 4'h9,
		P_HOLDA = 4'ha,
		P_CONT  = 4'hb,
		P_ALIGN = 4'hc,
		P_DATA  = 4'hd
	} flec_prim_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_XRDY = 3'b001,
		RX_RECV = 3'b010,
		RX_ACK  = 3'b011,
		RX_HOLD = 3'b100
	} flec_rx_st_t;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_XRDY = 3'b001,
		TX_SOF  = 3'b010,
		TX_DATA = 3'b011,
		TX_CRC  = 3'b100,
		TX_EOF  = 3'b101,
		TX_WTRM = 3'b110
	} flec_tx_st_t;

	typedef struct packed {
		logic        valid;
		flec_prim_t  prim;
		logic [31:0] data;
		logic        code_err;
	} flec_rx_t;

	typedef struct packed {
		logic type_bad;
		logic len_bad;
		logic pio_mismatch;
		logic seq_err;
		logic rx_ovf;
		logic internal;
	} flec_tp_err_t;

	typedef struct packed {
		logic crc;
		logic code;
		logic proto;
		logic xrdy_abort;
	} flec_lnk_err_t;

	typedef struct packed {
		logic        last;
		logic [31:0] data;
	} flec_word_t;

endpackage : flec_pkg

/* File: verilog/flec_buf2.sv */
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
module flec_buf2 #(
	parameter int W     = 33,
	parameter int DEPTH = 2
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic          push;
	logic          pop;

	assign in_ready  = (count != CW'(DEPTH));
	assign out_valid = (count != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
			end
			if (push && !pop) begin
				count <= CW'(count + 1'b1);
			end else if (pop && !push) begin
				count <= CW'(count - 1'b1);
			end
		end
	end

endmodule : flec_buf2

/* File: tb/flec_peer.sv */
// peer link model answering the block's transmitter
`timescale 1ns/1ps
module flec_peer (
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	input  wire flec_pkg::flec_prim_t tx_prim,
	input  wire logic [1:0]           mode,
	output flec_pkg::flec_rx_t        rx
);
	// ************
	// answers
	// ************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx <= '0;
		end else begin
			rx.valid    <= 1'b1;
			rx.code_err <= 1'b0;
			// data field means nothing outside frames, keep it moving
			rx.data     <= ~rx.data;
			case (tx_prim)
				flec_pkg::P_X_RDY: rx.prim <= flec_pkg::P_R_RDY;
				// mode 2 never closes the handshake
				flec_pkg::P_WTRM: rx.prim <= (mode == 2'h0) ? flec_pkg::P_R_OK :
					(mode == 2'h1) ? flec_pkg::P_R_ERR : flec_pkg::P_R_IP;
				flec_pkg::P_SYNC: rx.prim <= flec_pkg::P_SYNC;
				default: rx.prim <= flec_pkg::P_R_IP;
			endcase
		end
	end
endmodule : flec_peer

/* File: tb/flec_link_bench.sv */
// self-checking bench of the frame link error control block
`timescale 1ns/1ps
module flec_link_bench;
	// row fields: code_err, crc_bad, tp_err[5:0], frame_err, register[15:0]
	typedef logic [24:0] flec_row_t;
	flec_row_t rows [10] = '{25'h0, 25'h810001, 25'h1010002, 25'h410010, 25'h210020,
		25'h110040, 25'h090080, 25'h050100, 25'h030200, 25'h0};
	logic                    clk_sys, rst, rx_crc_bad, tx_req, tx_in_valid, cmd_start, own, retry;
	logic                    rx_word_valid, rx_frame_done, rx_frame_err, tx_in_ready;
	logic                    tx_done, tx_nak, tx_retry_ok, tx_ack_timeout, end_status_err;
	logic [1:0]              mode;
	logic [15:0]             ierr_clr, ier;
	logic [31:0]             tx_data, crc_seen;
	flec_pkg::flec_rx_t      tb_rx, peer_rx, rx;
	flec_pkg::flec_tp_err_t  tp_err;
	flec_pkg::flec_word_t    tx_in, rx_word;
	flec_pkg::flec_prim_t    tx_prim;
	flec_pkg::flec_lnk_err_t lnk_err;
	int                      n_fail = 0, checked = 0, cyc = 0, k, nw = 0;

	assign rx = own ? tb_rx : peer_rx;
	flec_link uut (.clk_sys(clk_sys), .rst(rst), .rx(rx), .rx_crc_bad(rx_crc_bad),
		.tp_err(tp_err), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
		.rx_frame_done(rx_frame_done), .rx_frame_err(rx_frame_err), .lnk_err(lnk_err),
		.tx_req(tx_req), .tx_retryable(retry), .tx_in(tx_in), .tx_in_valid(tx_in_valid),
		.tx_in_ready(tx_in_ready), .tx_crc(32'h1234abcd), .tx_prim(tx_prim),
		.tx_data(tx_data), .tx_done(tx_done), .tx_nak(tx_nak), .tx_retry_ok(tx_retry_ok),
		.tx_ack_timeout(tx_ack_timeout), .cmd_start(cmd_start),
		.end_status_err(end_status_err), .ierr_clr(ierr_clr), .interface_error_register(ier));
	flec_peer peer (.clk_sys(clk_sys), .rst(rst), .tx_prim(tx_prim), .mode(mode), .rx(peer_rx));

	// ************
	// tasks
	// ************
	task automatic test_done();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic sym(input flec_pkg::flec_prim_t p, input logic ce);
		@(posedge clk_sys);
		tb_rx <= '{1'b1, p, 32'h0000_00c3, ce};
	endtask : sym

	task automatic clr();
		@(posedge clk_sys);
		ierr_clr <= 16'hffff;
		@(posedge clk_sys);
		ierr_clr <= 16'h0000;
	endtask : clr

	task automatic rxf(input flec_row_t r);
		int n0;
		n0 = nw;
		sym(flec_pkg::P_X_RDY, 1'b0);
		sym(flec_pkg::P_X_RDY, 1'b0);
		sym(flec_pkg::P_SOF, 1'b0);
		tp_err <= r[22:17];
		sym(flec_pkg::P_DATA, r[24]);
		sym(flec_pkg::P_DATA, 1'b0);
		sym(flec_pkg::P_EOF, 1'b0);
		chk(lnk_err, {1'b0, r[24], 2'b00});
		rx_crc_bad <= r[23];
		sym(flec_pkg::P_WTRM, 1'b0);
		rx_crc_bad <= 1'b0;
		tp_err <= '0;
		for (k = 0; k < 8 && rx_frame_done !== 1'b1; k++) @(posedge clk_sys);
		chk(rx_frame_done, 1'b1);
		chk(nw - n0, 2);
		chk(rx_word.data, 32'h0000_00c3);
		chk(lnk_err, {r[23], 3'b000});
		chk(rx_frame_err, r[16]);
		@(posedge clk_sys);
		chk(tx_prim, r[16] ? flec_pkg::P_R_ERR : flec_pkg::P_R_OK);
		chk(ier, r[15:0]);
		sym(flec_pkg::P_SYNC, 1'b0);
		clr();
	endtask : rxf

	task automatic wt();
		for (k = 0; k < 3000 && tx_done !== 1'b1 && tx_nak !== 1'b1; k++) @(posedge clk_sys);
	endtask : wt

	task automatic txf(input logic [1:0] m, input logic lst);
		@(posedge clk_sys);
		mode <= m;
		// a frame cut by underrun stands for a data frame, never resent
		retry <= lst;
		tx_in <= '{1'b0, 32'h0000_00a1};
		tx_in_valid <= 1'b1;
		@(posedge clk_sys);
		tx_in <= '{lst, 32'h0000_00a2};
		@(posedge clk_sys);
		tx_in_valid <= 1'b0;
		tx_req <= 1'b1;
		for (k = 0; k < 20 && tx_prim !== flec_pkg::P_SOF; k++) @(posedge clk_sys);
		tx_req <= 1'b0;
		wt();
	endtask : txf

	// ************
	// sequence
	// ************
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cyc++;
		if (rx_word_valid === 1'b1) nw++;
		if (tx_prim === flec_pkg::P_DATA) crc_seen <= tx_data;
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end

	initial begin
		{rst, own, rx_crc_bad, tx_req, tx_in_valid, cmd_start} = 6'b110000;
		{mode, ierr_clr, tp_err, tx_in, retry} = '0;
		tb_rx = '{1'b1, flec_pkg::P_SYNC, 32'h0, 1'b0};
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk(tx_prim, flec_pkg::P_SYNC);
		chk({tx_in_ready, ier}, 17'h10000);
		for (int i = 0; i < 10; i++) rxf(rows[i]);
		chk(end_status_err, 1'b1);
		@(posedge clk_sys);
		cmd_start <= 1'b1;
		@(posedge clk_sys);
		cmd_start <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(end_status_err, 1'b0);
		sym(flec_pkg::P_X_RDY, 1'b0);
		sym(flec_pkg::P_DATA, 1'b0);
		sym(flec_pkg::P_SYNC, 1'b0);
		repeat (2) @(posedge clk_sys);
		chk(lnk_err, 4'h1);
		chk(ier, 16'h0008);
		clr();
		sym(flec_pkg::P_SOF, 1'b0);
		sym(flec_pkg::P_DATA, 1'b0);
		repeat (2) @(posedge clk_sys);
		chk(tx_prim, flec_pkg::P_SYNC);
		sym(flec_pkg::P_SYNC, 1'b0);
		clr();
		own <= 1'b0;
		txf(2'h0, 1'b1);
		chk(tx_done, 1'b1);
		chk(crc_seen, 32'h1234abcd);
		txf(2'h1, 1'b1);
		chk({tx_nak, tx_retry_ok}, 2'b11);
		repeat (3) @(posedge clk_sys);
		chk(ier, 16'h0800);
		txf(2'h1, 1'b0);
		chk({tx_nak, tx_retry_ok}, 2'b10);
		chk(crc_seen, ~32'h1234abcd);
		chk(ier, 16'h0c00);
		txf(2'h2, 1'b1);
		chk({tx_ack_timeout, tx_done, tx_nak}, 3'b100);
		mode <= 2'h0;
		wt();
		chk(tx_done, 1'b1);
		rst <= 1'b1;
		@(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk({end_status_err, ier}, 17'h00000);
		test_done();
	end
endmodule : flec_link_bench
